/* core/wsg_cfg.svh */
// Constants for the waveform setpoint generator
`ifndef WSG_CFG_SVH
`define WSG_CFG_SVH
`define WSG_VW 16
`define WSG_TW 32
`define WSG_CLK_HZ 25000000
`define WSG_TICK_NS 10000
`define WSG_TICK_CYC 250
`define WSG_TMAX 32'd3600000000
`define WSG_FMAX 16'd10000
`define WSG_RMAX 10'd999
`define WSG_NOM 16'hffff
`define WSG_ES_V0 16'h7800
`define WSG_ES_V1 16'h3c00
`define WSG_ES_V2 16'h5000
`define WSG_ES_V3 16'h5000
`define WSG_ES_V4 16'h7800
`define WSG_ES_T0 32'h00000001
`define WSG_ES_T1 32'h000003e8
`define WSG_ES_T2 32'h00000064
`define WSG_ES_T3 32'h00002710
`define WSG_ES_T4 32'h00000064
`endif

/* core/wsg_pkg.sv */
// Types for the waveform setpoint generator
package wsg_pkg;
  typedef enum logic [2:0] {WSG_SINE, WSG_TRI, WSG_RECT, WSG_TRAP, WSG_ESC} wsg_mode_e;
  typedef enum logic [2:0] {WSG_IDLE, WSG_READY, WSG_RUN, WSG_PAUSE} wsg_state_e;
endpackage

/* core/wsg_core.sv */
// Waveform setpoint generator core
`timescale 1ns/10ps
`include "wsg_cfg.svh"
//
// Contract
// - Load latches parameters, statics, input on
// - Static values output before and after run
// - Current target starts from zero amperes
// - Start or toggle-while-off begins run
// - Stop halts waveform, input stays on
// - Toggle during run halts and switches off
// - Alarm aborts, input off, alarm report
// - Sine offset plus amplitude; reject bad
// - Sine frequency constant, 1 to 10000 Hz
// - Triangle ramps up interval one, down two
// - Triangle period is sum of intervals
// - Rectangle high interval one, base two
// - Offset and amplitude within nominal
// - Trapezoid rise, top, fall, base phases
// - Engine curve: voltage only, five ramps
// - Engine points within nominal and time range
// - Engine points reset to standard curve
// - Curve repeats endlessly or 1 to 999
// - Pause between passes when count not one
// - Waveform drives one set value only
// - Parameters accepted only while input off
// - Unavailable in resistance regulation
module wsg_core
  import wsg_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] mode_sel,
  input wire logic target_current,
  input wire logic [15:0] amplitude,
  input wire logic [15:0] offset,
  input wire logic [15:0] sine_freq,
  input wire logic [31:0] first_interval,
  input wire logic [31:0] second_interval,
  input wire logic [31:0] third_interval,
  input wire logic [31:0] fourth_interval,
  input wire logic [31:0] repeat_pause,
  input wire logic [9:0] repeat_count,
  input wire logic [2:0] point_sel,
  input wire logic [15:0] point_start_v,
  input wire logic [15:0] point_end_v,
  input wire logic [31:0] point_time,
  input wire logic point_write,
  input wire logic [15:0] static_voltage,
  input wire logic [15:0] static_current,
  input wire logic load_cmd,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic onoff_toggle,
  input wire logic device_alarm,
  input wire logic power_protection_trip,
  input wire logic current_protection_trip,
  input wire logic event_alarm,
  input wire logic resistance_regulation,
  output logic power_on,
  output logic start_enabled,
  output logic running,
  output logic param_error,
  output logic alarm_report,
  output logic [15:0] voltage_set,
  output logic [15:0] current_set
);

  // ------------------------------------------------------------
  // Synchronisers for pins from outside
  // ------------------------------------------------------------
  localparam int NS = 8;
  logic [NS-1:0] raw, s1_q, s2_q, s3_q;
  assign raw = {load_cmd, start_cmd, stop_cmd, onoff_toggle, device_alarm,
                power_protection_trip, current_protection_trip, event_alarm};
  // Second stage feeds logic; third stage only for edge detection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic load_p, start_p, stop_p, tog_p, alarm_lv;
  assign load_p = s2_q[7] & ~s3_q[7];
  assign start_p = s2_q[6] & ~s3_q[6];
  assign stop_p = s2_q[5] & ~s3_q[5];
  assign tog_p = s2_q[4] & ~s3_q[4];
  assign alarm_lv = |s2_q[3:0];
  logic rr_s1_q, rr_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rr_s1_q <= 1'b0;
      rr_q <= 1'b0;
    end else begin
      rr_s1_q <= resistance_regulation;
      rr_q <= rr_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Tick of 0.01 ms
  // ------------------------------------------------------------
  localparam int TICK_CYC = `WSG_TICK_CYC;
  logic [8:0] pre_q;
  logic tick;
  logic go;
  assign tick = (pre_q == 9'(TICK_CYC - 1));
  // Restart on a start so the first phase is a whole number of ticks, not cut short
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) pre_q <= '0;
    else pre_q <= (tick || go) ? 9'h000 : pre_q + 9'h001;
  end

  // ------------------------------------------------------------
  // Latched parameters and engine points
  // ------------------------------------------------------------
  wsg_mode_e mode_q;
  logic tgt_i_q;
  logic [15:0] amp_q, off_q, fr_q, sv_q, si_q;
  logic [31:0] iv_q [4];
  logic [31:0] pause_q;
  logic [9:0] rep_q;
  logic [15:0] ps_q [5];
  logic [15:0] pe_q [5];
  logic [31:0] pt_q [5];
  wsg_state_e st_q;
  logic bad;
  logic [16:0] sum;
  assign sum = {1'b0, amplitude} + {1'b0, offset};
  // Sine demands offset not below amplitude; all shapes but the engine curve keep sum within nominal
  always_comb begin
    bad = (sum > 17'(`WSG_NOM));
    if (mode_sel == 3'(WSG_SINE))
      bad = bad | (offset < amplitude) | (sine_freq == 16'h0000) | (sine_freq > `WSG_FMAX);
    if (mode_sel > 3'(WSG_ESC))
      bad = 1'b1;
    if (first_interval == 32'h0 || first_interval > `WSG_TMAX || second_interval == 32'h0 ||
        second_interval > `WSG_TMAX)
      bad = 1'b1;
    if (mode_sel == 3'(WSG_TRAP) && (third_interval == 32'h0 || fourth_interval == 32'h0 ||
        third_interval > `WSG_TMAX || fourth_interval > `WSG_TMAX))
      bad = 1'b1;
    if (mode_sel == 3'(WSG_ESC) && (repeat_count > `WSG_RMAX || repeat_pause == 32'h0 ||
        repeat_pause > `WSG_TMAX))
      bad = 1'b1;
    if (mode_sel == 3'(WSG_ESC))
      bad = (repeat_count > `WSG_RMAX) | (repeat_pause == 32'h0) | (repeat_pause > `WSG_TMAX);
  end
  logic load_ok;
  // Loading only while off and outside resistance regulation
  assign load_ok = load_p & ~power_on & ~bad & ~rr_q & ~alarm_lv;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= WSG_SINE;
      tgt_i_q <= 1'b0;
      amp_q <= '0;
      off_q <= '0;
      fr_q <= 16'h0001;
      sv_q <= '0;
      si_q <= '0;
      pause_q <= 32'h1;
      rep_q <= 10'h001;
      for (int k = 0; k < 4; k++) iv_q[k] <= 32'h1;
    end else if (load_ok) begin
      mode_q <= wsg_mode_e'(mode_sel);
      tgt_i_q <= target_current & (mode_sel != 3'(WSG_ESC));
      amp_q <= amplitude;
      off_q <= offset;
      fr_q <= sine_freq;
      sv_q <= static_voltage;
      si_q <= static_current;
      pause_q <= repeat_pause;
      rep_q <= repeat_count;
      iv_q[0] <= first_interval;
      iv_q[1] <= second_interval;
      iv_q[2] <= third_interval;
      iv_q[3] <= fourth_interval;
    end
  end
  logic pt_ok;
  assign pt_ok = point_write & ~power_on & (point_sel < 3'd5) & (point_time != 32'h0) &
                 (point_time <= `WSG_TMAX);
  localparam logic [15:0] DEF_V [6] = '{`WSG_ES_V0, `WSG_ES_V1, `WSG_ES_V2, `WSG_ES_V3, `WSG_ES_V4, `WSG_ES_V4};
  localparam logic [31:0] DEF_T [5] = '{`WSG_ES_T0, `WSG_ES_T1, `WSG_ES_T2, `WSG_ES_T3, `WSG_ES_T4};
  // Engine points hold the standard curve after reset
  for (genvar g = 0; g < 5; g++) begin : g_pt
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        ps_q[g] <= DEF_V[g];
        pe_q[g] <= DEF_V[g+1];
        pt_q[g] <= DEF_T[g];
      end else if (pt_ok && point_sel == 3'(g)) begin
        ps_q[g] <= point_start_v;
        pe_q[g] <= point_end_v;
        pt_q[g] <= point_time;
      end
    end
  end

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  logic [31:0] tc_q;
  logic [2:0] ph_q;
  logic [9:0] done_q;
  logic [31:0] plen;
  logic ph_end, last_ph;
  // A toggle starts the run only while the input is off; while on it just switches off
  assign go = (st_q == WSG_READY) & (start_p | (tog_p & ~power_on)) & ~alarm_lv;
  always_comb begin
    plen = iv_q[ph_q[1:0]];
    if (mode_q == WSG_ESC) plen = (ph_q < 3'd5) ? pt_q[ph_q] : 32'h1;
    if (mode_q == WSG_SINE) plen = 32'hffffffff;
  end
  assign ph_end = tick & (tc_q + 32'h1 >= plen);
  always_comb begin
    case (mode_q)
      WSG_TRI, WSG_RECT: last_ph = (ph_q == 3'd1);
      WSG_TRAP: last_ph = (ph_q == 3'd3);
      WSG_ESC: last_ph = (ph_q == 3'd4);
      default: last_ph = 1'b0;
    endcase
  end
  logic esc_more;
  assign esc_more = (rep_q == 10'h000) | (done_q + 10'h001 < rep_q);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= WSG_IDLE;
      power_on <= 1'b0;
      alarm_report <= 1'b0;
      param_error <= 1'b0;
      tc_q <= '0;
      ph_q <= '0;
      done_q <= '0;
    end else begin
      if (load_p) param_error <= bad | rr_q;
      if (alarm_lv) alarm_report <= 1'b1;
      else if (load_ok) alarm_report <= 1'b0;
      if (alarm_lv) begin
        st_q <= (st_q == WSG_IDLE) ? WSG_IDLE : WSG_READY;
        power_on <= 1'b0;
      end else if (rr_q) begin
        st_q <= WSG_IDLE;
        power_on <= 1'b0;
      end else begin
        case (st_q)
          WSG_IDLE: begin
            if (load_ok) begin
              st_q <= WSG_READY;
              power_on <= 1'b1;
            end
          end
          WSG_READY: begin
            if (go) begin
              st_q <= WSG_RUN;
              power_on <= 1'b1;
              tc_q <= '0;
              ph_q <= '0;
              done_q <= '0;
            end else if (tog_p) power_on <= 1'b0;
            else if (load_ok) power_on <= 1'b1;
          end
          WSG_RUN, WSG_PAUSE: begin
            if (tog_p) begin
              st_q <= WSG_READY;
              power_on <= 1'b0;
            end else if (stop_p) st_q <= WSG_READY;
            else if (st_q == WSG_PAUSE) begin
              if (tick) tc_q <= tc_q + 32'h1;
              if (tick && tc_q + 32'h1 >= pause_q) begin
                st_q <= WSG_RUN;
                tc_q <= '0;
              end
            end else if (ph_end) begin
              tc_q <= '0;
              ph_q <= last_ph ? 3'd0 : ph_q + 3'd1;
              if (last_ph && mode_q == WSG_ESC) begin
                done_q <= done_q + 10'h001;
                if (!esc_more) st_q <= WSG_READY;
                else if (rep_q != 10'h001) st_q <= WSG_PAUSE;
              end
            end else if (tick) tc_q <= tc_q + 32'h1;
          end
          default: st_q <= WSG_IDLE;
        endcase
      end
    end
  end
  assign running = (st_q == WSG_RUN) | (st_q == WSG_PAUSE);
  assign start_enabled = (st_q == WSG_READY) & power_on;

  // ------------------------------------------------------------
  // Waveform value
  // ------------------------------------------------------------
  // Sine phase accumulator: 32-bit phase stepped once per tick
  logic [31:0] acc_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) acc_q <= '0;
    else if (st_q != WSG_RUN) acc_q <= '0;
    else if (tick) acc_q <= acc_q + 32'(fr_q) * 32'd42950;
  end
  // Parabolic sine approximation; a trade of accuracy for area
  logic [15:0] ramp_up, ramp_dn, sine_mag;
  logic [47:0] prod;
  logic [15:0] frac;
  logic [31:0] span;
  assign span = (plen == 32'h0) ? 32'h1 : plen;
  assign prod = {tc_q, 16'h0000} / {16'h0000, span};
  assign frac = prod[15:0];
  logic [16:0] tri_x;
  assign tri_x = acc_q[30] ? {1'b0, ~acc_q[29:14]} : {1'b0, acc_q[29:14]};
  // Product kept at full width; x*(2-x) stays below 2^32 for a 16-bit quarter phase
  logic [33:0] sq;
  assign sq = {17'h00000, tri_x} * (34'h000020000 - {17'h00000, tri_x});
  assign sine_mag = sq[31:16];
  logic [31:0] am;
  logic [31:0] wf;
  logic [15:0] es_s, es_e;
  assign es_s = ps_q[(ph_q < 3'd5) ? ph_q : 3'd0];
  assign es_e = pe_q[(ph_q < 3'd5) ? ph_q : 3'd0];
  always_comb begin
    am = 32'({16'h0000, amp_q} * {16'h0000, frac}) >> 16;
    ramp_up = am[15:0];
    ramp_dn = amp_q - am[15:0];
    wf = {16'h0000, off_q};
    case (mode_q)
      WSG_SINE: begin
        am = 32'({16'h0000, amp_q} * {16'h0000, sine_mag}) >> 16;
        wf = acc_q[31] ? {16'h0000, off_q} - am : {16'h0000, off_q} + am;
      end
      WSG_TRI: wf = {16'h0000, off_q} + {16'h0000, (ph_q == 3'd0) ? ramp_up : ramp_dn};
      WSG_RECT: wf = (ph_q == 3'd0) ? {16'h0000, off_q} + {16'h0000, amp_q} : {16'h0000, off_q};
      WSG_TRAP: begin
        case (ph_q)
          3'd0: wf = {16'h0000, off_q} + {16'h0000, ramp_up};
          3'd1: wf = {16'h0000, off_q} + {16'h0000, amp_q};
          3'd2: wf = {16'h0000, off_q} + {16'h0000, ramp_dn};
          default: wf = {16'h0000, off_q};
        endcase
      end
      WSG_ESC: begin
        if (st_q == WSG_PAUSE) wf = {16'h0000, pe_q[4]};
        else if (es_e >= es_s)
          wf = {16'h0000, es_s} + (32'({16'h0000, es_e - es_s} * {16'h0000, frac}) >> 16);
        else
          wf = {16'h0000, es_s} - (32'({16'h0000, es_s - es_e} * {16'h0000, frac}) >> 16);
      end
      default: wf = {16'h0000, off_q};
    endcase
  end
  logic [15:0] sat;
  assign sat = (wf[31:16] != 16'h0000) ? `WSG_NOM : wf[15:0];
  // Registered set values; statics outside a run, zero current when current is the target
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      voltage_set <= '0;
      current_set <= '0;
    end else begin
      voltage_set <= (st_q == WSG_RUN || st_q == WSG_PAUSE) && !tgt_i_q ? sat : sv_q;
      current_set <= (st_q == WSG_RUN) && tgt_i_q ? sat : (tgt_i_q ? 16'h0000 : si_q);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_stop_req;
    stop_p && !tog_p && !alarm_lv && !rr_q && running;
  endsequence
  a_alarm_power_off: assert property (@(posedge clock) disable iff (!arst_n)
    alarm_lv |=> !power_on && !running && alarm_report) else $error("alarm did not abort");
  a_stop_keeps_on: assert property (@(posedge clock) disable iff (!arst_n)
    s_stop_req |=> power_on && !running) else $error("stop changed power state");
  a_toggle_off: assert property (@(posedge clock) disable iff (!arst_n)
    running && tog_p && !alarm_lv |=> !power_on && !running) else $error("toggle kept input on");
  a_start_runs: assert property (@(posedge clock) disable iff (!arst_n)
    go && !rr_q |=> running && power_on) else $error("start did not run");
  a_load_ready: assert property (@(posedge clock) disable iff (!arst_n)
    load_ok && st_q == WSG_IDLE && !rr_q |=> start_enabled) else $error("load did not arm start");
  a_static_idle: assert property (@(posedge clock) disable iff (!arst_n)
    !running && !$past(running) && !tgt_i_q |=> voltage_set == $past(sv_q)) else $error("static voltage lost");
  a_current_zero: assert property (@(posedge clock) disable iff (!arst_n)
    tgt_i_q && st_q != WSG_RUN |=> current_set == 16'h0000) else $error("current not zero");
  a_rr_blocks: assert property (@(posedge clock) disable iff (!arst_n)
    rr_q |=> !running) else $error("generator ran in resistance mode");
  a_no_load_on: assert property (@(posedge clock) disable iff (!arst_n)
    power_on && load_p |=> $stable(mode_q)) else $error("parameters changed while on");
  a_tick_span: assert property (@(posedge clock) disable iff (!arst_n)
    tick |=> !tick [*8]) else $error("tick too frequent");

endmodule

/* sim/wsg_stage_model.sv */
// Behavioural power stage that raises protection trips on command
`timescale 1ns/10ps
module wsg_stage_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic power_on,
  input wire logic [15:0] current_set,
  input wire logic [1:0] trip_en,
  output logic power_protection_trip,
  output logic current_protection_trip
);
  // ------------------------------------------------------------
  // Trip flags
  // ------------------------------------------------------------
  // A stage only trips while it conducts, so trips vanish once the input is off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_protection_trip <= 1'b0;
      current_protection_trip <= 1'b0;
    end else begin
      power_protection_trip <= power_on & trip_en[1];
      current_protection_trip <= power_on & trip_en[0] & (current_set != 16'h0000);
    end
  end
endmodule

/* sim/waveform_setpoint_generator_tb.sv */
// Self-checking bench for the waveform setpoint generator
`timescale 1ns/10ps
`include "wsg_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module waveform_setpoint_generator_tb import wsg_pkg::*; ;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clock, arst_n, target_current, point_write, load_cmd, start_cmd, stop_cmd, onoff_toggle;
  logic device_alarm, event_alarm, resistance_regulation, meas_i;
  logic [2:0] mode_sel, point_sel;
  logic [1:0] trip_en;
  logic [9:0] repeat_count;
  logic [15:0] amplitude, offset, sine_freq, point_start_v, point_end_v, static_voltage, static_current;
  logic [31:0] first_interval, second_interval, third_interval, fourth_interval, repeat_pause, point_time;
  logic power_protection_trip, current_protection_trip, power_on, start_enabled, running, param_error;
  logic alarm_report;
  logic [15:0] voltage_set, current_set;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;

  wsg_core dut (.clock(clock), .arst_n(arst_n), .mode_sel(mode_sel), .target_current(target_current),
    .amplitude(amplitude), .offset(offset), .sine_freq(sine_freq), .first_interval(first_interval),
    .second_interval(second_interval), .third_interval(third_interval), .fourth_interval(fourth_interval),
    .repeat_pause(repeat_pause), .repeat_count(repeat_count), .point_sel(point_sel),
    .point_start_v(point_start_v), .point_end_v(point_end_v), .point_time(point_time),
    .point_write(point_write), .static_voltage(static_voltage), .static_current(static_current),
    .load_cmd(load_cmd), .start_cmd(start_cmd), .stop_cmd(stop_cmd), .onoff_toggle(onoff_toggle),
    .device_alarm(device_alarm), .power_protection_trip(power_protection_trip),
    .current_protection_trip(current_protection_trip), .event_alarm(event_alarm),
    .resistance_regulation(resistance_regulation), .power_on(power_on), .start_enabled(start_enabled),
    .running(running), .param_error(param_error), .alarm_report(alarm_report),
    .voltage_set(voltage_set), .current_set(current_set));

  wsg_stage_model stage (.clock(clock), .arst_n(arst_n), .power_on(power_on), .current_set(current_set),
    .trip_en(trip_en), .power_protection_trip(power_protection_trip),
    .current_protection_trip(current_protection_trip));

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Whole run needs about 15000 cycles, so 80000 means a hang
  always @(posedge clock) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Pins pass a two-stage synchroniser, so a pulse is held five cycles
  task automatic cmd(input int k);
    @(posedge clock);
    case (k)
      0: load_cmd <= 1'b1;
      1: start_cmd <= 1'b1;
      2: stop_cmd <= 1'b1;
      default: onoff_toggle <= 1'b1;
    endcase
    tick(4);
    @(posedge clock);
    {load_cmd, start_cmd, stop_cmd, onoff_toggle} <= 4'h0;
    tick(6);
  endtask
  task automatic setup(input logic [2:0] m, input logic tc, input logic [15:0] a, o, f,
                       input logic [31:0] d1, d2, d3, d4);
    @(posedge clock);
    mode_sel <= m;
    target_current <= tc;
    amplitude <= a;
    offset <= o;
    sine_freq <= f;
    {first_interval, second_interval, third_interval, fourth_interval} <= {d1, d2, d3, d4};
  endtask
  function automatic logic [15:0] smp();
    return meas_i ? current_set : voltage_set;
  endfunction
  // Waits for a level, then counts how long it stands
  task automatic hold_len(input logic [15:0] v, output int n);
    int w;
    for (w = 0; w < 4000 && smp() !== v; w++) tick(1);
    for (n = 0; n < 4000 && smp() === v; n++) tick(1);
  endtask
  // Cycles between two upward crossings of a level
  task automatic period(input logic [15:0] lv, output int n);
    int w;
    for (w = 0; w < 4000 && smp() >= lv; w++) tick(1);
    for (w = 0; w < 4000 && smp() < lv; w++) tick(1);
    for (n = 0; n < 4000 && smp() >= lv; n++) tick(1);
    for (w = 0; w < 4000 && smp() < lv; w++) tick(1);
    n += w;
  endtask
  task automatic span(input int k, output logic [15:0] lo, hi);
    lo = 16'hffff;
    hi = 16'h0000;
    repeat (k) begin
      tick(1);
      if (smp() < lo) lo = smp();
      if (smp() > hi) hi = smp();
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_errors();
    logic [2:0] em [5] = '{WSG_SINE, WSG_SINE, WSG_SINE, WSG_TRI, WSG_TRI};
    logic [15:0] ea [5] = '{16'h2000, 16'h0100, 16'h0100, 16'h9000, 16'h0100};
    logic [15:0] eo [5] = '{16'h1000, 16'h1000, 16'h1000, 16'h8000, 16'h1000};
    logic [15:0] ef [5] = '{16'd100, 16'd0, 16'd10001, 16'd100, 16'd100};
    logic [31:0] e1 [5] = '{32'd2, 32'd2, 32'd2, 32'd2, 32'd0};
    for (int i = 0; i < 5; i++) begin
      setup(em[i], 1'b0, ea[i], eo[i], ef[i], e1[i], 32'd2, 32'd2, 32'd2);
      cmd(0);
      `CHK("param_error", 1'b1, param_error)
      `CHK("power_on", 1'b0, power_on)
    end
    setup(WSG_SINE, 1'b0, 16'h03e8, 16'h07d0, 16'd10000, 32'd2, 32'd2, 32'd2, 32'd2);
    resistance_regulation <= 1'b1;
    cmd(0);
    `CHK("power_on", 1'b0, power_on)
    @(posedge clock) resistance_regulation <= 1'b0;
    tick(6);
  endtask
  task automatic s_run();
    logic [15:0] lo, hi;
    cmd(0);
    `CHK("power_on", 1'b1, power_on)
    `CHK("start_enabled", 1'b1, start_enabled)
    `CHK("running", 1'b0, running)
    `CHK("voltage_set", 16'h4000, voltage_set)
    `CHK("current_set", 16'h0500, current_set)
    @(posedge clock) static_voltage <= 16'h4100;
    cmd(0);
    `CHK("voltage_set", 16'h4000, voltage_set)
    @(posedge clock) static_voltage <= 16'h4000;
    cmd(1);
    `CHK("running", 1'b1, running)
    `CHK("start_enabled", 1'b0, start_enabled)
    span(2500, lo, hi);
    `CHK("sine_range", 1'b1, lo >= 16'h03e0 && hi <= 16'h0bc0)
    `CHK("sine_swing", 1'b1, lo <= 16'h0480 && hi >= 16'h0b00)
    `CHK("current_set", 16'h0500, current_set)
    cmd(2);
    `CHK("running", 1'b0, running)
    `CHK("power_on", 1'b1, power_on)
    `CHK("voltage_set", 16'h4000, voltage_set)
    cmd(1);
    cmd(3);
    `CHK("power_on", 1'b0, power_on)
    `CHK("running", 1'b0, running)
    cmd(1);
    `CHK("running", 1'b1, running)
    `CHK("power_on", 1'b1, power_on)
    cmd(3);
    cmd(3);
    `CHK("running", 1'b1, running)
    `CHK("power_on", 1'b1, power_on)
    cmd(3);
  endtask
  task automatic s_shapes();
    int n;
    logic [15:0] lo, hi;
    meas_i = 1'b1;
    setup(WSG_RECT, 1'b1, 16'h03e8, 16'h07d0, 16'd100, 32'd2, 32'd3, 32'd2, 32'd2);
    cmd(0);
    `CHK("current_set", 16'h0000, current_set)
    cmd(1);
    hold_len(16'h0bb8, n);
    hold_len(16'h07d0, n);
    `CHK("rect_low", 750, n)
    hold_len(16'h0bb8, n);
    `CHK("rect_high", 500, n)
    cmd(3);
    meas_i = 1'b0;
    setup(WSG_TRI, 1'b0, 16'h03e8, 16'h0000, 16'd100, 32'd2, 32'd2, 32'd2, 32'd2);
    cmd(0);
    cmd(1);
    span(1000, lo, hi);
    `CHK("tri_top", 1'b1, hi <= 16'h03e8 && hi >= 16'h03d0)
    `CHK("tri_base", 1'b1, lo <= 16'h0018)
    period(16'h01f4, n);
    `CHK("tri_period", 1'b1, n >= 997 && n <= 1003)
    cmd(3);
    setup(WSG_TRAP, 1'b0, 16'h03e8, 16'h0000, 16'd100, 32'd1, 32'd2, 32'd1, 32'd2);
    cmd(0);
    cmd(1);
    hold_len(16'h03e8, n);
    hold_len(16'h03e8, n);
    // The fall's first held sample is still the top, so the top shows one tick past interval two
    `CHK("trap_top", 1'b1, n >= 750 && n <= 752)
    period(16'h01f4, n);
    `CHK("trap_period", 1'b1, n >= 1497 && n <= 1503)
    cmd(3);
  endtask
  task automatic s_alarm();
    for (int k = 0; k < 4; k++) begin
      setup(WSG_RECT, 1'b0, 16'h03e8, 16'h07d0, 16'd100, 32'd2, 32'd2, 32'd2, 32'd2);
      cmd(0);
      if (k > 0) `CHK("alarm_report", 1'b0, alarm_report)
      cmd(1);
      @(posedge clock);
      case (k)
        0: device_alarm <= 1'b1;
        1: trip_en <= 2'b01;
        2: trip_en <= 2'b10;
        default: event_alarm <= 1'b1;
      endcase
      tick(10);
      `CHK("running", 1'b0, running)
      `CHK("power_on", 1'b0, power_on)
      `CHK("alarm_report", 1'b1, alarm_report)
      @(posedge clock) {device_alarm, event_alarm, trip_en} <= 4'h0;
      tick(6);
    end
  endtask
  task automatic s_engine();
    int n;
    logic seen;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      point_sel <= 3'(i);
      point_start_v <= 16'(16'h1000 * (i + 1));
      point_end_v <= 16'(16'h1000 * (i + 1));
      point_time <= 32'd1;
      point_write <= 1'b1;
    end
    @(posedge clock);
    point_write <= 1'b0;
    repeat_count <= 10'd2;
    repeat_pause <= 32'd1;
    setup(WSG_ESC, 1'b1, 16'h0000, 16'h0000, 16'd100, 32'd1, 32'd1, 32'd1, 32'd1);
    cmd(0);
    cmd(1);
    seen = 1'b0;
    for (n = 0; n < 8000 && running === 1'b1; n++) begin
      tick(1);
      if (voltage_set === 16'h3000) seen = 1'b1;
    end
    `CHK("point_level", 1'b1, seen)
    `CHK("run_length", 1'b1, n >= 2735 && n <= 3005)
    // Set values follow the state one clock later
    tick(1);
    `CHK("current_set", 16'h0500, current_set)
    `CHK("voltage_set", 16'h4000, voltage_set)
    `CHK("power_on", 1'b1, power_on)
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {arst_n, target_current, point_write, load_cmd, start_cmd, stop_cmd, onoff_toggle} = 7'h00;
    {device_alarm, event_alarm, resistance_regulation, meas_i, mode_sel, point_sel, trip_en} = 12'h000;
    {amplitude, offset, sine_freq, point_start_v, point_end_v} = 80'h0;
    {first_interval, second_interval, third_interval, fourth_interval, point_time} = 160'h0;
    repeat_pause = 32'd1;
    repeat_count = 10'd1;
    static_voltage = 16'h4000;
    static_current = 16'h0500;
    tick(4);
    `CHK("reset_outputs", 37'h0, {power_on, start_enabled, running, param_error, alarm_report, voltage_set, current_set})
    @(posedge clock);
    arst_n <= 1'b1;
    tick(4);
    s_errors();
    setup(WSG_SINE, 1'b0, 16'h03e8, 16'h07d0, 16'd10000, 32'd2, 32'd2, 32'd2, 32'd2);
    s_run();
    s_shapes();
    s_alarm();
    s_engine();
    test_done();
  end
endmodule
